// File: hdl/seal_temp_monitor.sv
// seal temperature status monitor: reached flag, ok window flag, irq
// assumes temperatures and set point come from logic on ref_clk_i
//
// Decided for this implementation: the address-and-strobe port and the address map.
module seal_temp_monitor
   import seal_mon_pkg::*;
#(
   parameter logic [PERIOD_W-1:0] MIN_CYC = PERIOD_W'(PERIOD_MIN_CYC),
   parameter logic [PERIOD_W-1:0] MAX_CYC = PERIOD_W'(PERIOD_MAX_CYC)
)
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic line_zc_i,
   input wire logic start_i,
   input wire logic alarm_i,
   input wire logic [TEMP_W-1:0] actual_temp_i,
   input wire logic [TEMP_W-1:0] set_temp_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic temp_reached_o,
   output logic temp_ok_o,
   output logic signed [TEMP_W:0] ctrl_err_o,
   output logic meas_o,
   output logic irq_o
);
   // ----------------------------------------------------------------
   // pins and line timing
   // ----------------------------------------------------------------
   logic zc_rise;
   logic start_rise;
   logic alarm_lvl;
   logic meas;
   logic freq_fault;
   logic locked;
   logic [PERIOD_W-1:0] period;
   pin_sync u_zc_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(line_zc_i),
      .level_o(),
      .rise_o(zc_rise)
   );
   pin_sync u_start_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(start_i),
      .level_o(),
      .rise_o(start_rise)
   );
   pin_sync u_alarm_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(alarm_i),
      .level_o(alarm_lvl),
      .rise_o()
   );
   line_period_meter #(
      .MIN_CYC(MIN_CYC),
      .MAX_CYC(MAX_CYC)
   ) u_meter (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .zc_rise_i(zc_rise),
      .meas_o(meas),
      .fault_o(freq_fault),
      .locked_o(locked),
      .period_o(period)
   );
   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   logic [1:0] ctrl_q;
   logic [7:0] tol_lo_q;
   logic [7:0] tol_hi_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic wr_ctrl;
   logic cfg_reject;
   logic reached_en;
   logic ok_en;
   assign wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
   assign cfg_reject = wr_ctrl && wdata_i[CTRL_REACHED_BIT]
                       && wdata_i[CTRL_OK_BIT];
   assign reached_en = ctrl_q[CTRL_REACHED_BIT];
   assign ok_en = ctrl_q[CTRL_OK_BIT];
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ctrl_q <= CTRL_RESET;
      else if (wr_ctrl && !cfg_reject)
         ctrl_q <= {wdata_i[CTRL_OK_BIT], wdata_i[CTRL_REACHED_BIT]};
   end
   // each offset has its own write decode
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         tol_lo_q <= TOL_LO_RESET;
      else if (wr_i && addr_i == ADDR_TOL_LO)
         tol_lo_q <= wdata_i[7:0];
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         tol_hi_q <= TOL_HI_RESET;
      else if (wr_i && addr_i == ADDR_TOL_HI)
         tol_hi_q <= wdata_i[7:0];
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         irq_mask_q <= IRQ_MASK_RESET;
      else if (wr_i && addr_i == ADDR_IRQ_MASK)
         irq_mask_q <= wdata_i[IRQ_W-1:0];
   end
   // ----------------------------------------------------------------
   // measurement evaluation
   // ----------------------------------------------------------------
   logic win_now;
   logic in_win_q;
   logic reached_now;
   assign win_now = in_window(actual_temp_i, set_temp_i, tol_lo_q,
                              tol_hi_q);
   assign reached_now = above_95(actual_temp_i, set_temp_i);
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         in_win_q <= 1'b0;
         ctrl_err_o <= '0;
         meas_o <= 1'b0;
      end
      else
      begin
         meas_o <= meas;
         if (meas)
         begin
            in_win_q <= win_now;
            ctrl_err_o <= $signed({1'b0, set_temp_i})
                          - $signed({1'b0, actual_temp_i});
         end
      end
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         temp_reached_o <= 1'b0;
      else if (!reached_en)
         temp_reached_o <= 1'b0;
      else if (meas)
         temp_reached_o <= reached_now;
   end
   // ok window flag: alarm first, then window loss, then arming by start
   logic ok_lost;
   assign ok_lost = temp_ok_o && meas && !win_now;
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         temp_ok_o <= 1'b0;
      else if (!ok_en || alarm_lvl)
         temp_ok_o <= 1'b0;
      else if (meas && !win_now)
         temp_ok_o <= 1'b0;
      else if (start_rise)
         temp_ok_o <= in_win_q;
   end
   // ----------------------------------------------------------------
   // interrupts and read port
   // ----------------------------------------------------------------
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_evt;
   logic rd_stat;
   assign rd_stat = rd_i && (addr_i == ADDR_IRQ_STAT);
   always_comb
   begin
      irq_evt = '0;
      irq_evt[IRQ_OK_LOST] = ok_lost;
      irq_evt[IRQ_REACHED] = reached_en && meas && reached_now
                             && !temp_reached_o;
      irq_evt[IRQ_FREQ_FAULT] = freq_fault;
      irq_evt[IRQ_CFG_REJECT] = cfg_reject;
   end
   // a new event wins over the clear by read
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         irq_stat_q <= '0;
      else
         irq_stat_q <= (rd_stat ? '0 : irq_stat_q) | irq_evt;
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(irq_stat_q & irq_mask_q);
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_o <= '0;
      else if (!rd_i)
         rdata_o <= '0;
      else
      begin
         unique case (addr_i)
            ADDR_CTRL: rdata_o <= {30'h0, ctrl_q};
            ADDR_TOL_LO: rdata_o <= {24'h0, tol_lo_q};
            ADDR_TOL_HI: rdata_o <= {24'h0, tol_hi_q};
            ADDR_STATUS: rdata_o <= {28'h0, in_win_q, locked, temp_ok_o,
                                     temp_reached_o};
            ADDR_IRQ_STAT: rdata_o <= {{(32-IRQ_W){1'b0}}, irq_stat_q};
            ADDR_IRQ_MASK: rdata_o <= {{(32-IRQ_W){1'b0}}, irq_mask_q};
            ADDR_PERIOD: rdata_o <= {{(32-PERIOD_W){1'b0}}, period};
            ADDR_CTRL_ERR: rdata_o <= 32'(signed'(ctrl_err_o));
            default: rdata_o <= '0;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_ctrl_error: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      meas |=> ctrl_err_o == $signed({1'b0, $past(set_temp_i)})
               - $signed({1'b0, $past(actual_temp_i)}))
      else $error("control error not set minus actual");
   chk_reached_value: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      meas && reached_en |=> temp_reached_o
         == above_95($past(actual_temp_i), $past(set_temp_i)))
      else $error("reached flag wrong at measurement");
   chk_reached_hold: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !meas && reached_en |=> $stable(temp_reached_o))
      else $error("reached flag moved between measurements");
   chk_reached_off: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !reached_en |=> !temp_reached_o)
      else $error("reached flag high with its option off");
   chk_tol_reset: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> tol_lo_q == TOL_LO_RESET
                         && tol_hi_q == TOL_HI_RESET)
      else $error("tolerance offsets not at reset value");
   chk_tol_indep: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_i && addr_i == ADDR_TOL_LO |=> $stable(tol_hi_q))
      else $error("upper offset moved on lower write");
   chk_tol_indep_hi: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_i && addr_i == ADDR_TOL_HI |=> $stable(tol_lo_q))
      else $error("lower offset moved on upper write");
   chk_ok_arm: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      start_rise && ok_en && !alarm_lvl && !meas
      |=> temp_ok_o == $past(in_win_q))
      else $error("ok flag not armed from window at start");
   chk_ok_drop: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      meas && !win_now |=> !temp_ok_o ##1 (!temp_ok_o || $past(start_rise)))
      else $error("ok flag survived leaving the window");
   chk_ok_hold: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !temp_ok_o && !start_rise |=> !temp_ok_o)
      else $error("ok flag rose without start");
   chk_alarm_kill: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      alarm_lvl |=> !temp_ok_o)
      else $error("ok flag high during alarm");
   chk_ok_option: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !ok_en |=> !temp_ok_o)
      else $error("ok flag high with its option off");
   chk_one_option: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !(reached_en && ok_en) && !(temp_ok_o && temp_reached_o))
      else $error("both options active");
   chk_cfg_keep: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      cfg_reject |=> $stable(ctrl_q))
      else $error("rejected setting changed the options");
   chk_window_edge: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !meas |=> $stable(in_win_q))
      else $error("window state moved between measurements");
   chk_stat_set_wins: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      |irq_evt |=> (irq_stat_q & $past(irq_evt)) == $past(irq_evt))
      else $error("interrupt event lost against a status clear");
   // ----------------------------------------------------------------
   // scenario coverage
   // ----------------------------------------------------------------
   cov_freq_fault: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      freq_fault);
   cov_ok_armed: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      start_rise ##1 temp_ok_o);
   cov_ok_lost: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ok_lost);
   cov_reached: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(temp_reached_o));
   cov_cfg_reject: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cfg_reject);
endmodule

// File: hdl/seal_mon_pkg.sv
// constants, register map and helper functions of the seal temperature monitor
// assumes a single 200 MHz clock and an asynchronous active-low reset
package seal_mon_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;
   localparam int LINE_MIN_HZ = 47;
   localparam int LINE_MAX_HZ = 63;
   localparam int PERIOD_W = 23;
   // shortest period rounds up, longest rounds down
   localparam int PERIOD_MIN_CYC = (CLK_HZ + LINE_MAX_HZ - 1) / LINE_MAX_HZ;
   localparam int PERIOD_MAX_CYC = CLK_HZ / LINE_MIN_HZ;
   // ----------------------------------------------------------------
   // register map (word addresses) and fields
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_TOL_LO = 4'h1;
   localparam logic [3:0] ADDR_TOL_HI = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
   localparam logic [3:0] ADDR_PERIOD = 4'h6;
   localparam logic [3:0] ADDR_CTRL_ERR = 4'h7;
   localparam int CTRL_REACHED_BIT = 0;
   localparam int CTRL_OK_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [7:0] TOL_LO_RESET = 8'h0a;
   localparam logic [7:0] TOL_HI_RESET = 8'h0a;
   localparam int IRQ_OK_LOST = 0;
   localparam int IRQ_REACHED = 1;
   localparam int IRQ_FREQ_FAULT = 2;
   localparam int IRQ_CFG_REJECT = 3;
   localparam int IRQ_W = 4;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
   localparam int TEMP_W = 16;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic above_95(input logic [TEMP_W-1:0] act,
                                     input logic [TEMP_W-1:0] set);
      logic [TEMP_W+4:0] a20;
      logic [TEMP_W+4:0] s19;
      a20 = (TEMP_W+5)'(act) * (TEMP_W+5)'(20);
      s19 = (TEMP_W+5)'(set) * (TEMP_W+5)'(19);
      return a20 > s19;
   endfunction
   function automatic logic in_window(input logic [TEMP_W-1:0] act,
                                      input logic [TEMP_W-1:0] set,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
      logic signed [TEMP_W+1:0] a;
      logic signed [TEMP_W+1:0] l;
      logic signed [TEMP_W+1:0] h;
      a = $signed({2'b00, act});
      l = $signed({2'b00, set}) - $signed({{(TEMP_W-6){1'b0}}, lo});
      h = $signed({2'b00, set}) + $signed({{(TEMP_W-6){1'b0}}, hi});
      return (a >= l) && (a <= h);
   endfunction
endpackage

// File: hdl/pin_sync.sv
// three-stage synchroniser for a pin input with agreement filter
// assumes the pin is asynchronous to ref_clk_i
module pin_sync
   import seal_mon_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end
      else
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // a change counts once stages two and three agree
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         level_o <= 1'b0;
         rise_o <= 1'b0;
      end
      else
      begin
         rise_o <= (s2_q == s3_q) && s3_q && !level_o;
         if (s2_q == s3_q)
            level_o <= s3_q;
      end
   end
endmodule

// File: hdl/line_period_meter.sv
// measures the line period between zero crossings, paces measurements
// assumes zc_rise_i is a synchronised one-cycle pulse per line period
module line_period_meter
   import seal_mon_pkg::*;
#(
   parameter logic [PERIOD_W-1:0] MIN_CYC = PERIOD_W'(PERIOD_MIN_CYC),
   parameter logic [PERIOD_W-1:0] MAX_CYC = PERIOD_W'(PERIOD_MAX_CYC)
)
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic zc_rise_i,
   output logic meas_o,
   output logic fault_o,
   output logic locked_o,
   output logic [PERIOD_W-1:0] period_o
);
   logic [PERIOD_W-1:0] cnt_q;
   logic ok_len;
   assign ok_len = (cnt_q >= MIN_CYC) && (cnt_q <= MAX_CYC);
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= '0;
         meas_o <= 1'b0;
         fault_o <= 1'b0;
         locked_o <= 1'b0;
         period_o <= '0;
      end
      else
      begin
         meas_o <= 1'b0;
         fault_o <= 1'b0;
         if (zc_rise_i)
         begin
            cnt_q <= PERIOD_W'(1);
            locked_o <= ok_len;
            meas_o <= ok_len;
            fault_o <= !ok_len && locked_o;
            if (ok_len)
               period_o <= cnt_q;
         end
         else if (cnt_q <= MAX_CYC)
            cnt_q <= cnt_q + PERIOD_W'(1);
         else if (locked_o)
         begin
            locked_o <= 1'b0;
            fault_o <= 1'b1;
         end
      end
   end
   chk_meas_paced: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      meas_o |-> locked_o && period_o >= MIN_CYC && period_o <= MAX_CYC)
      else $error("measurement outside locked line period");
   chk_lock_range: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      zc_rise_i && !ok_len |=> !locked_o && !meas_o)
      else $error("lock kept on out-of-range period");
endmodule

// File: dv/seal_ctrl_model.sv
// machine controller model: line zero-cross source and START driver
// assumes the bench paces it on ref_clk_i and chooses the line period
module seal_ctrl_model
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] period_i,
   input wire logic start_req_i,
   input wire logic temp_ok_i,
   output logic line_zc_o,
   output logic start_o,
   output logic ok_seen_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] phase_q;
   logic [3:0] hold_q;
   // ------------------------------------------------------------
   // line half waves; a zero period leaves the line still and low
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i || period_i == 8'h00)
      begin
         phase_q <= 8'h00;
         line_zc_o <= 1'b0;
      end
      else
      begin
         phase_q <= (phase_q >= period_i - 8'h01) ? 8'h00 : phase_q + 8'h01;
         line_zc_o <= (phase_q < (period_i >> 1));
      end
   end
   // ------------------------------------------------------------
   // start pulse of ten cycles; ok is read just before it
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         hold_q <= 4'h0;
         start_o <= 1'b0;
         ok_seen_o <= 1'b0;
      end
      else if (start_req_i && hold_q == 4'h0)
      begin
         ok_seen_o <= temp_ok_i;
         hold_q <= 4'ha;
         start_o <= 1'b1;
      end
      else
      begin
         hold_q <= (hold_q == 4'h0) ? 4'h0 : hold_q - 4'h1;
         start_o <= (hold_q > 4'h1);
      end
   end
endmodule

// File: dv/seal_temp_monitor_bench.sv
// self-checking bench of the seal temperature status monitor
// assumes short line period limits of 40 and 60 clocks in the design
module seal_temp_monitor_bench
   import seal_mon_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i, rst_n_i, start_req, alarm_i, rd_i, wr_i, smp, rd_d;
   logic reach_on;
   logic [3:0] addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic [TEMP_W-1:0] act, setp;
   logic [7:0] period;
   logic line_zc, start, ok_seen, temp_reached_o, temp_ok_o, meas_o, irq_o;
   logic signed [TEMP_W:0] ctrl_err_o;
   logic [31:0] rq[$], mq[$], oq[$];
   int n_errors, total_checks, cyc, gap;
   integer seed;

   seal_temp_monitor #(.MIN_CYC(PERIOD_W'(40)), .MAX_CYC(PERIOD_W'(60))) i_dut
   (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .line_zc_i(line_zc),
    .start_i(start), .alarm_i(alarm_i), .actual_temp_i(act),
    .set_temp_i(setp), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .temp_reached_o(temp_reached_o),
    .temp_ok_o(temp_ok_o), .ctrl_err_o(ctrl_err_o), .meas_o(meas_o),
    .irq_o(irq_o));

   seal_ctrl_model i_ctrl
   (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .period_i(period),
    .start_req_i(start_req), .temp_ok_i(temp_ok_o), .line_zc_o(line_zc),
    .start_o(start), .ok_seen_o(ok_seen));

   initial
   begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      n_errors += rq.size() + mq.size() + oq.size();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // gap counts clocks between measurement pulses
   always @(posedge ref_clk_i)
   begin
      rd_d <= rd_i;
      gap <= meas_o ? 1 : gap + 1;
      cyc++;
      if (cyc > 20000)
      begin
         n_errors++;
         stop_test();
      end
   end
   always @(negedge ref_clk_i)
   begin
      if (rd_d)
         check(rdata_o, rq.pop_front());
      if (meas_o && mq.size() > 0)
         check({6'h0, 8'(gap), temp_reached_o, ctrl_err_o},
               mq.pop_front());
      if (smp)
         check({28'h0, ok_seen, irq_o, temp_ok_o, temp_reached_o},
               oq.pop_front());
   end
   // ------------------------------------------------------------
   // drivers; rd, obs and mchk queue their expectation before the cycle that is checked
   // ------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      rq.push_back(exp);
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
   endtask
   task automatic obs(input logic [3:0] exp);
      @(posedge ref_clk_i);
      smp <= 1'b1;
      oq.push_back({28'h0, exp});
      @(posedge ref_clk_i);
      smp <= 1'b0;
   endtask
   task automatic wait_meas();
      int i;
      i = 0;
      do
      begin
         @(negedge ref_clk_i);
         i++;
      end
      while (meas_o !== 1'b1 && i < 300);
      if (meas_o !== 1'b1)
         n_errors++;
      @(posedge ref_clk_i);
   endtask
   // new temperatures, then the second measurement after them is judged
   task automatic mchk(input logic [TEMP_W-1:0] a, input logic [TEMP_W-1:0] s);
      logic signed [TEMP_W:0] e;
      logic r;
      @(posedge ref_clk_i);
      act <= a;
      setp <= s;
      e = $signed({1'b0, s}) - $signed({1'b0, a});
      r = reach_on && (32'(a) * 20 > 32'(s) * 19);
      wait_meas();
      mq.push_back({6'h0, period, r, e});
      wait_meas();
   endtask
   task automatic start_seal();
      @(posedge ref_clk_i);
      start_req <= 1'b1;
      @(posedge ref_clk_i);
      start_req <= 1'b0;
      repeat (16) @(posedge ref_clk_i);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      {rst_n_i, start_req, alarm_i, rd_i, wr_i, smp, reach_on} = '0;
      addr_i = 4'h0;
      wdata_i = 32'h0;
      act = '0;
      setp = '0;
      period = 8'd50;
      seed = 66;
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_TOL_LO, 32'h0a);
      rd(ADDR_TOL_HI, 32'h0a);
      rd(ADDR_IRQ_MASK, 32'h0);
      wr(4'h9, 32'h5a);
      rd(4'h9, 32'h0);
      wr(ADDR_TOL_LO, 32'h05);
      rd(ADDR_TOL_HI, 32'h0a);
      wr(ADDR_TOL_HI, 32'h07);
      rd(ADDR_TOL_LO, 32'h05);
      wr(ADDR_IRQ_MASK, 32'h8);
      rd(ADDR_IRQ_MASK, 32'h8);
      wr(ADDR_CTRL, 32'h3);
      rd(ADDR_CTRL, 32'h0);
      obs(4'b0100);
      rd(ADDR_IRQ_STAT, 32'h8);
      rd(ADDR_IRQ_STAT, 32'h0);
      obs(4'b0000);
      wr(ADDR_CTRL, 32'h1);
      reach_on = 1'b1;
      mchk(16'd190, 16'd200);
      mchk(16'd191, 16'd200);
      obs(4'b0001);
      mchk(16'd0, 16'd200);
      mchk(16'd250, 16'd200);
      rd(ADDR_CTRL_ERR, 32'hffffffce);
      rd(ADDR_PERIOD, 32'd50);
      period <= 8'd45;
      repeat (6)
         mchk(16'($unsigned($random(seed)) % 600),
              16'(100 + $unsigned($random(seed)) % 400));
      rd(ADDR_PERIOD, 32'd45);
      wr(ADDR_CTRL, 32'h2);
      reach_on = 1'b0;
      mchk(16'd195, 16'd200);
      start_seal();
      obs(4'b0010);
      rd(ADDR_STATUS, 32'he);
      mchk(16'd207, 16'd200);
      obs(4'b0010);
      start_seal();
      obs(4'b1010);
      mchk(16'd208, 16'd200);
      obs(4'b1000);
      mchk(16'd200, 16'd200);
      obs(4'b1000);
      start_seal();
      obs(4'b0010);
      alarm_i <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      obs(4'b0000);
      alarm_i <= 1'b0;
      mchk(16'd190, 16'd200);
      start_seal();
      obs(4'b0000);
      rd(ADDR_IRQ_STAT, 32'h3);
      wr(ADDR_IRQ_MASK, 32'h4);
      period <= 8'd0;
      repeat (100) @(posedge ref_clk_i);
      obs(4'b0100);
      rd(ADDR_STATUS, 32'h0);
      rd(ADDR_IRQ_STAT, 32'h4);
      obs(4'b0000);
      stop_test();
   end
endmodule
